// [med_pkg.sv]
// Package for the motion event detector: register map, field layout, reset values.
// Assumes one clock domain and an AXI4-Lite master with 32-bit data.
//
// Contract
// - Wake interrupt-active flag resets to 0 and sets on any enabled wake event.
// - Wake source holds six per-axis above/below flags, reset 0, set on event.
// - With latching on, reading wake acknowledge refreshes wake source; data meaningless (code clears wake source to 0).
// - Wake threshold is 16 bits, low byte then high byte at next address.
// - Wake event counts only after condition persists programmed samples.
// - Direction interrupt output driven only while direction enable bit is 1.
// - Direction config holds six per-axis enables, reset 0.
// - With direction latch on, requests latch; reading direction acknowledge clears them.
// - Direction source flag sets when direction differs from previous measurement.
// - Axis above flag sets past outer threshold positive; clears below inner threshold.
// - Axis below flag sets past outer threshold negative; clears below inner threshold.
// - Inner direction threshold is 16 bits from two consecutive byte registers.
// - Outer direction threshold is 16 bits from two consecutive byte registers.
// - Combine bit 0 ORs enabled wake events, 1 ANDs them.
// - Wake latch bit chooses held source flags or live condition.
// - Wake config holds six per-axis above/below enables, reset 0.

package med_pkg;

   // ---------------------------------------------------------------
   // Register indices and byte addresses
   // ---------------------------------------------------------------
   localparam logic [7:0] IDX_WAKE_CONFIG = 8'h30;
   localparam logic [7:0] IDX_WAKE_SOURCE = 8'h31;
   localparam logic [7:0] IDX_WAKE_ACK = 8'h32;
   localparam logic [7:0] IDX_WAKE_THR_LO = 8'h34;
   localparam logic [7:0] IDX_WAKE_THR_HI = 8'h35;
   localparam logic [7:0] IDX_WAKE_DUR = 8'h36;
   localparam logic [7:0] IDX_DIR_CONFIG = 8'h38;
   localparam logic [7:0] IDX_DIR_SOURCE = 8'h39;
   localparam logic [7:0] IDX_DIR_ACK = 8'h3a;
   localparam logic [7:0] IDX_DIR_IN_LO = 8'h3c;
   localparam logic [7:0] IDX_DIR_IN_HI = 8'h3d;
   localparam logic [7:0] IDX_DIR_OUT_LO = 8'h3e;
   localparam logic [7:0] IDX_DIR_OUT_HI = 8'h3f;
   localparam logic [7:0] IDX_IRQ_STATUS = 8'h40;
   localparam logic [7:0] IDX_IRQ_MASK = 8'h41;
   localparam int ADDR_W = 10;
   localparam int IDX_LSB = 2;

   // ---------------------------------------------------------------
   // Field positions
   // ---------------------------------------------------------------
   localparam int BIT_COMBINE = 7;
   localparam int BIT_DIR_IRQ_EN = 7;
   localparam int BIT_LATCH = 6;
   localparam int BIT_ACTIVE = 6;
   localparam int IRQ_BIT_WAKE = 0;
   localparam int IRQ_BIT_DIR = 1;
   localparam int IRQ_W = 2;

   // ---------------------------------------------------------------
   // Reset values and bus answers
   // ---------------------------------------------------------------
   localparam logic [7:0] RST_BYTE = 8'h00;
   localparam logic [15:0] RST_THR = 16'h0000;
   localparam logic [IRQ_W-1:0] RST_IRQ = 2'h0;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef struct packed {
      logic signed [15:0] x;
      logic signed [15:0] y;
      logic signed [15:0] z;
   } med_sample_s;

   // Per-axis flags: {z_above, z_below, y_above, y_below, x_above, x_below}
   typedef logic [5:0] med_axis_flags_t;

endpackage

// [med_motion_event_detect.sv]
// Motion event detector: wake/free-fall and direction detectors with an AXI4-Lite slave.
// Assumes samples arrive on the same clock, marked by a one-cycle sample_valid.
`timescale 1ns/1ps

module med_motion_event_detect
(
   aclk,
   aresetn,
   sample_valid,
   sample,
   wake_irq,
   direction_irq,
   irq,
   s_axi_awaddr,
   s_axi_awvalid,
   s_axi_awready,
   s_axi_wdata,
   s_axi_wstrb,
   s_axi_wvalid,
   s_axi_wready,
   s_axi_bresp,
   s_axi_bvalid,
   s_axi_bready,
   s_axi_araddr,
   s_axi_arvalid,
   s_axi_arready,
   s_axi_rdata,
   s_axi_rresp,
   s_axi_rvalid,
   s_axi_rready
);
   input wire logic aclk;
   input wire logic aresetn;
   input wire logic sample_valid;
   input wire med_pkg::med_sample_s sample;
   output logic wake_irq;
   output logic direction_irq;
   output logic irq;
   input wire logic [med_pkg::ADDR_W-1:0] s_axi_awaddr;
   input wire logic s_axi_awvalid;
   output logic s_axi_awready;
   input wire logic [31:0] s_axi_wdata;
   input wire logic [3:0] s_axi_wstrb;
   input wire logic s_axi_wvalid;
   output logic s_axi_wready;
   output logic [1:0] s_axi_bresp;
   output logic s_axi_bvalid;
   input wire logic s_axi_bready;
   input wire logic [med_pkg::ADDR_W-1:0] s_axi_araddr;
   input wire logic s_axi_arvalid;
   output logic s_axi_arready;
   output logic [31:0] s_axi_rdata;
   output logic [1:0] s_axi_rresp;
   output logic s_axi_rvalid;
   input wire logic s_axi_rready;

   // ---------------------------------------------------------------
   // Registers
   // ---------------------------------------------------------------
   logic [7:0] wake_cfg_ff;
   logic [15:0] wake_thr_ff;
   logic [7:0] wake_dur_ff;
   logic [7:0] dir_cfg_ff;
   logic [15:0] dir_in_thr_ff;
   logic [15:0] dir_out_thr_ff;
   logic [7:0] wake_src_ff;
   logic [7:0] dir_src_ff;
   logic [7:0] wake_cnt_ff;
   med_pkg::med_axis_flags_t dir_state_ff;
   logic [med_pkg::IRQ_W-1:0] irq_stat_ff;
   logic [med_pkg::IRQ_W-1:0] irq_mask_ff;

   // ---------------------------------------------------------------
   // AXI4-Lite write channel
   // ---------------------------------------------------------------
   logic [med_pkg::ADDR_W-1:0] aw_addr_ff;
   logic aw_held_ff;
   logic [31:0] w_data_ff;
   logic [3:0] w_strb_ff;
   logic w_held_ff;
   logic wr_do;
   logic [7:0] wr_idx;
   logic wr_hit;

   assign s_axi_awready = !aw_held_ff && !s_axi_bvalid;
   assign s_axi_wready = !w_held_ff && !s_axi_bvalid;
   assign wr_do = aw_held_ff && w_held_ff;
   assign wr_idx = 8'(aw_addr_ff >> med_pkg::IDX_LSB);

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         aw_held_ff <= 1'b0;
         w_held_ff <= 1'b0;
         aw_addr_ff <= '0;
         w_data_ff <= '0;
         w_strb_ff <= '0;
      end
      else
      begin
         if (s_axi_awvalid && s_axi_awready)
         begin
            aw_held_ff <= 1'b1;
            aw_addr_ff <= s_axi_awaddr;
         end
         else if (wr_do)
         begin
            aw_held_ff <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready)
         begin
            w_held_ff <= 1'b1;
            w_data_ff <= s_axi_wdata;
            w_strb_ff <= s_axi_wstrb;
         end
         else if (wr_do)
         begin
            w_held_ff <= 1'b0;
         end
      end
   end

   always_comb
   begin
      unique case (wr_idx)
         med_pkg::IDX_WAKE_CONFIG, med_pkg::IDX_WAKE_THR_LO, med_pkg::IDX_WAKE_THR_HI,
         med_pkg::IDX_WAKE_DUR, med_pkg::IDX_DIR_CONFIG, med_pkg::IDX_DIR_IN_LO,
         med_pkg::IDX_DIR_IN_HI, med_pkg::IDX_DIR_OUT_LO, med_pkg::IDX_DIR_OUT_HI,
         med_pkg::IDX_IRQ_MASK: wr_hit = (aw_addr_ff[1:0] == 2'h0);
         default: wr_hit = 1'b0;
      endcase
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= med_pkg::RESP_OKAY;
      end
      else if (wr_do)
      begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp <= wr_hit ? med_pkg::RESP_OKAY : med_pkg::RESP_SLVERR;
      end
      else if (s_axi_bready)
      begin
         s_axi_bvalid <= 1'b0;
      end
   end

   // Configuration and threshold bytes; only lane 0 carries data
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         wake_cfg_ff <= med_pkg::RST_BYTE;
         wake_thr_ff <= med_pkg::RST_THR;
         wake_dur_ff <= med_pkg::RST_BYTE;
         dir_cfg_ff <= med_pkg::RST_BYTE;
         dir_in_thr_ff <= med_pkg::RST_THR;
         dir_out_thr_ff <= med_pkg::RST_THR;
         irq_mask_ff <= med_pkg::RST_IRQ;
      end
      else if (wr_do && wr_hit && w_strb_ff[0])
      begin
         unique case (wr_idx)
            med_pkg::IDX_WAKE_CONFIG: wake_cfg_ff <= w_data_ff[7:0];
            med_pkg::IDX_WAKE_THR_LO: wake_thr_ff[7:0] <= w_data_ff[7:0];
            med_pkg::IDX_WAKE_THR_HI: wake_thr_ff[15:8] <= w_data_ff[7:0];
            med_pkg::IDX_WAKE_DUR: wake_dur_ff <= w_data_ff[7:0];
            med_pkg::IDX_DIR_CONFIG: dir_cfg_ff <= w_data_ff[7:0];
            med_pkg::IDX_DIR_IN_LO: dir_in_thr_ff[7:0] <= w_data_ff[7:0];
            med_pkg::IDX_DIR_IN_HI: dir_in_thr_ff[15:8] <= w_data_ff[7:0];
            med_pkg::IDX_DIR_OUT_LO: dir_out_thr_ff[7:0] <= w_data_ff[7:0];
            med_pkg::IDX_DIR_OUT_HI: dir_out_thr_ff[15:8] <= w_data_ff[7:0];
            med_pkg::IDX_IRQ_MASK: irq_mask_ff <= w_data_ff[med_pkg::IRQ_W-1:0];
            default: irq_mask_ff <= irq_mask_ff;
         endcase
      end
   end

   // ---------------------------------------------------------------
   // AXI4-Lite read channel
   // ---------------------------------------------------------------
   logic [7:0] rd_idx;
   logic rd_take;
   logic rd_ack_wake;
   logic rd_ack_dir;
   logic rd_irq_stat;
   logic [31:0] nxt_rdata;
   logic rd_hit;

   assign s_axi_arready = !s_axi_rvalid;
   assign rd_take = s_axi_arvalid && s_axi_arready;
   assign rd_idx = 8'(s_axi_araddr >> med_pkg::IDX_LSB);
   assign rd_ack_wake = rd_take && rd_hit && (rd_idx == med_pkg::IDX_WAKE_ACK);
   assign rd_ack_dir = rd_take && rd_hit && (rd_idx == med_pkg::IDX_DIR_ACK);
   assign rd_irq_stat = rd_take && rd_hit && (rd_idx == med_pkg::IDX_IRQ_STATUS);

   always_comb
   begin
      nxt_rdata = '0;
      rd_hit = (s_axi_araddr[1:0] == 2'h0);
      unique case (rd_idx)
         med_pkg::IDX_WAKE_CONFIG: nxt_rdata[7:0] = wake_cfg_ff;
         med_pkg::IDX_WAKE_SOURCE: nxt_rdata[7:0] = wake_src_ff;
         med_pkg::IDX_WAKE_ACK: nxt_rdata = '0;
         med_pkg::IDX_WAKE_THR_LO: nxt_rdata[7:0] = wake_thr_ff[7:0];
         med_pkg::IDX_WAKE_THR_HI: nxt_rdata[7:0] = wake_thr_ff[15:8];
         med_pkg::IDX_WAKE_DUR: nxt_rdata[7:0] = wake_dur_ff;
         med_pkg::IDX_DIR_CONFIG: nxt_rdata[7:0] = dir_cfg_ff;
         med_pkg::IDX_DIR_SOURCE: nxt_rdata[7:0] = dir_src_ff;
         med_pkg::IDX_DIR_ACK: nxt_rdata = '0;
         med_pkg::IDX_DIR_IN_LO: nxt_rdata[7:0] = dir_in_thr_ff[7:0];
         med_pkg::IDX_DIR_IN_HI: nxt_rdata[7:0] = dir_in_thr_ff[15:8];
         med_pkg::IDX_DIR_OUT_LO: nxt_rdata[7:0] = dir_out_thr_ff[7:0];
         med_pkg::IDX_DIR_OUT_HI: nxt_rdata[7:0] = dir_out_thr_ff[15:8];
         med_pkg::IDX_IRQ_STATUS: nxt_rdata[med_pkg::IRQ_W-1:0] = irq_stat_ff;
         med_pkg::IDX_IRQ_MASK: nxt_rdata[med_pkg::IRQ_W-1:0] = irq_mask_ff;
         default: rd_hit = 1'b0;
      endcase
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= '0;
         s_axi_rresp <= med_pkg::RESP_OKAY;
      end
      else if (rd_take)
      begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata <= rd_hit ? nxt_rdata : '0;
         s_axi_rresp <= rd_hit ? med_pkg::RESP_OKAY : med_pkg::RESP_SLVERR;
      end
      else if (s_axi_rready)
      begin
         s_axi_rvalid <= 1'b0;
      end
   end

   // ---------------------------------------------------------------
   // Per-axis comparisons
   // ---------------------------------------------------------------
   logic signed [16:0] axis_val [3];
   med_pkg::med_axis_flags_t wake_live;
   med_pkg::med_axis_flags_t dir_out_hit;
   med_pkg::med_axis_flags_t dir_in_low;

   assign axis_val[0] = {sample.x[15], sample.x};
   assign axis_val[1] = {sample.y[15], sample.y};
   assign axis_val[2] = {sample.z[15], sample.z};

   // Magnitudes are unsigned 16-bit; one extra bit keeps negation of a 65535 threshold exact
   for (genvar a = 0; a < 3; a++)
   begin : g_axis
      logic signed [16:0] thr_w;
      logic signed [16:0] thr_o;
      logic signed [16:0] thr_i;
      assign thr_w = {1'b0, wake_thr_ff};
      assign thr_o = {1'b0, dir_out_thr_ff};
      assign thr_i = {1'b0, dir_in_thr_ff};
      assign wake_live[2*a+1] = axis_val[a] > thr_w;
      assign wake_live[2*a] = axis_val[a] < -thr_w;
      assign dir_out_hit[2*a+1] = axis_val[a] > thr_o;
      assign dir_out_hit[2*a] = axis_val[a] < -thr_o;
      assign dir_in_low[2*a+1] = axis_val[a] < thr_i;
      assign dir_in_low[2*a] = axis_val[a] > -thr_i;
   end

   // ---------------------------------------------------------------
   // Wake / free-fall detector
   // ---------------------------------------------------------------
   med_pkg::med_axis_flags_t wake_en;
   logic wake_cond;
   logic wake_event;

   assign wake_en = wake_cfg_ff[5:0];
   always_comb
   begin
      if (wake_cfg_ff[med_pkg::BIT_COMBINE])
      begin
         wake_cond = (wake_en != '0) && ((wake_live & wake_en) == wake_en);
      end
      else
      begin
         wake_cond = |(wake_live & wake_en);
      end
   end

   // Event once the condition has held the programmed number of samples
   assign wake_event = wake_cond && (wake_cnt_ff >= wake_dur_ff);

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         wake_cnt_ff <= '0;
      end
      else if (sample_valid)
      begin
         if (!wake_cond)
         begin
            wake_cnt_ff <= '0;
         end
         else if (wake_cnt_ff != 8'hff)
         begin
            wake_cnt_ff <= wake_cnt_ff + 8'h01;
         end
      end
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         wake_src_ff <= med_pkg::RST_BYTE;
      end
      else if (sample_valid)
      begin
         if (!wake_cfg_ff[med_pkg::BIT_LATCH])
         begin
            wake_src_ff <= {1'b0, wake_event, wake_live & wake_en};
         end
         else if (rd_ack_wake)
         begin
            wake_src_ff <= {1'b0, wake_event, wake_live & wake_en};
         end
         else
         begin
            wake_src_ff <= wake_src_ff | {1'b0, wake_event, wake_live & wake_en};
         end
      end
      else if (rd_ack_wake && wake_cfg_ff[med_pkg::BIT_LATCH])
      begin
         wake_src_ff <= med_pkg::RST_BYTE;
      end
   end

   assign wake_irq = wake_src_ff[med_pkg::BIT_ACTIVE];

   // ---------------------------------------------------------------
   // Direction detector
   // ---------------------------------------------------------------
   med_pkg::med_axis_flags_t nxt_dir_state;
   logic dir_change;
   med_pkg::med_axis_flags_t dir_req;

   // Hysteresis: set past outer threshold, clear short of inner threshold (above flag: below +inner, below flag: above -inner)
   assign nxt_dir_state = (dir_state_ff | dir_out_hit) & ~dir_in_low;
   assign dir_req = nxt_dir_state & dir_cfg_ff[5:0];
   assign dir_change = (dir_req != (dir_state_ff & dir_cfg_ff[5:0]));

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         dir_state_ff <= '0;
      end
      else if (sample_valid)
      begin
         dir_state_ff <= nxt_dir_state;
      end
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         dir_src_ff <= med_pkg::RST_BYTE;
      end
      else if (sample_valid)
      begin
         if (!dir_cfg_ff[med_pkg::BIT_LATCH] || rd_ack_dir)
         begin
            dir_src_ff <= {1'b0, dir_change, dir_req};
         end
         else
         begin
            dir_src_ff <= dir_src_ff | {1'b0, dir_change, dir_req};
         end
      end
      else if (rd_ack_dir && dir_cfg_ff[med_pkg::BIT_LATCH])
      begin
         dir_src_ff <= med_pkg::RST_BYTE;
      end
   end

   assign direction_irq = dir_cfg_ff[med_pkg::BIT_DIR_IRQ_EN]
                          && dir_src_ff[med_pkg::BIT_ACTIVE];

   // ---------------------------------------------------------------
   // Interrupt status, mask and output
   // ---------------------------------------------------------------
   logic [med_pkg::IRQ_W-1:0] irq_set;

   assign irq_set[med_pkg::IRQ_BIT_WAKE] = sample_valid && wake_event;
   assign irq_set[med_pkg::IRQ_BIT_DIR] = sample_valid && dir_change
                                          && dir_cfg_ff[med_pkg::BIT_DIR_IRQ_EN];

   // Set wins over the clear-on-read in the same cycle
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         irq_stat_ff <= med_pkg::RST_IRQ;
      end
      else
      begin
         irq_stat_ff <= (rd_irq_stat ? med_pkg::RST_IRQ : irq_stat_ff) | irq_set;
      end
   end

   assign irq = |(irq_stat_ff & irq_mask_ff);

endmodule // med_motion_event_detect

// [med_motion_event_detect_properties.sv]
// Concurrent checks on the ports of the motion event detector.
// Bound to med_motion_event_detect; one clock, synchronous active-low reset.
`timescale 1ns/1ps

module med_motion_event_detect_properties
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic sample_valid,
   input wire logic wake_irq,
   input wire logic direction_irq,
   input wire logic irq,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready
);
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);

   // ---------------------------------------------------------------
   // Event outputs
   // ---------------------------------------------------------------
   AST_RST_QUIET: assert property ($rose(aresetn) |-> !wake_irq && !direction_irq && !irq)
      else $error("outputs not low after reset");
   AST_WAKE_RISE: assert property ($rose(wake_irq) |-> $past(sample_valid))
      else $error("wake flag rose without a sample");
   AST_WAKE_FALL: assert property ($fell(wake_irq) |->
      $past(sample_valid) || $past(s_axi_arvalid) || $past(s_axi_rvalid))
      else $error("wake flag fell without sample or read");
   AST_DIR_RISE: assert property ($rose(direction_irq) |-> $past(sample_valid)
      || $past(s_axi_wvalid) || $past(s_axi_wvalid, 2) || $past(s_axi_bvalid))
      else $error("direction output rose without cause");
   AST_IRQ_RISE: assert property ($rose(irq) |-> $past(sample_valid)
      || $past(s_axi_wvalid) || $past(s_axi_wvalid, 2) || $past(s_axi_bvalid))
      else $error("interrupt rose without cause");

   // ---------------------------------------------------------------
   // Register bus
   // ---------------------------------------------------------------
   AST_WR_RESP: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
      |-> !s_axi_bvalid ##2 s_axi_bvalid)
      else $error("write response not two cycles after request");
   AST_RD_RESP: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read data not one cycle after request");
   AST_RD_BLOCK: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("read accepted while data pending");
   AST_RD_ONE: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
      else $error("read data held after handshake");
   AST_WR_ONE: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
      else $error("write response held after handshake");
endmodule // med_motion_event_detect_properties

bind med_motion_event_detect med_motion_event_detect_properties i_props
(
   .aclk(aclk), .aresetn(aresetn), .sample_valid(sample_valid), .wake_irq(wake_irq),
   .direction_irq(direction_irq), .irq(irq), .s_axi_awvalid(s_axi_awvalid),
   .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
   .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
   .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready)
);

// [med_host_model.sv]
// Host controller model: AXI4-Lite master with one write and one read task.
// Assumes the slave shares aclk; hangs are cut by the bench timeout.
`timescale 1ns/1ps

module med_host_model
(
   input wire logic aclk,
   output logic [med_pkg::ADDR_W-1:0] awaddr,
   output logic awvalid,
   input wire logic awready,
   output logic [31:0] wdata,
   output logic [3:0] wstrb,
   output logic wvalid,
   input wire logic wready,
   input wire logic bvalid,
   output logic bready,
   output logic [med_pkg::ADDR_W-1:0] araddr,
   output logic arvalid,
   input wire logic arready,
   input wire logic [31:0] rdata,
   input wire logic [1:0] rresp,
   input wire logic rvalid,
   output logic rready
);
   initial {awaddr, awvalid, wdata, wstrb, wvalid, bready, araddr, arvalid, rready} = '0;

   task automatic wr(input logic [7:0] idx, input logic [7:0] v);
      logic aw_done = 1'b0;
      logic w_done = 1'b0;
      @(posedge aclk);
      awaddr <= {idx, 2'h0};
      wdata <= {24'h000000, v};
      wstrb <= 4'hf;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      while (!(aw_done && w_done))
      begin
         @(posedge aclk);
         aw_done |= awready;
         w_done |= wready;
         if (aw_done)
            awvalid <= 1'b0;
         if (w_done)
            wvalid <= 1'b0;
      end
      do @(posedge aclk); while (!bvalid);
      bready <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] idx, output logic [31:0] d, output logic [1:0] r);
      @(posedge aclk);
      araddr <= {idx, 2'h0};
      arvalid <= 1'b1;
      rready <= 1'b1;
      do @(posedge aclk); while (!arready);
      arvalid <= 1'b0;
      do @(posedge aclk); while (!rvalid);
      d = rdata;
      r = rresp;
      rready <= 1'b0;
   endtask
endmodule // med_host_model

// [med_motion_event_detect_tb.sv]
// Self-checking bench for the motion event detector.
// Samples come from the bench, registers go through the host model.
`timescale 1ns/1ps

module med_motion_event_detect_tb;
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic sample_valid = 1'b0;
   med_pkg::med_sample_s sample = '0;
   logic wake_irq, direction_irq, irq;
   logic [med_pkg::ADDR_W-1:0] awaddr, araddr;
   logic awvalid, awready, wvalid, wready, bvalid, bready;
   logic arvalid, arready, rvalid, rready;
   logic [31:0] wdata, rdata, d;
   logic [3:0] wstrb;
   logic [1:0] rresp, r, bresp;
   int fail_count = 0;
   int check_count = 0;
   int cyc = 0;

   always #2 aclk = ~aclk;

   med_motion_event_detect i_med_motion_event_detect
   (
      .aclk(aclk), .aresetn(aresetn), .sample_valid(sample_valid), .sample(sample),
      .wake_irq(wake_irq), .direction_irq(direction_irq), .irq(irq),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready)
   );

   med_host_model i_med_host_model
   (
      .aclk(aclk), .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata),
      .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bvalid(bvalid), .bready(bready),
      .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
      .rvalid(rvalid), .rready(rready)
   );

   // ---------------------------------------------------------------
   // Shared helpers
   // ---------------------------------------------------------------
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp)
      begin
         $display("Error at %0t: got %h expected %h", $time, got, exp);
         fail_count++;
      end
   endtask

   task automatic rc(input logic [7:0] idx, input logic [31:0] exp);
      i_med_host_model.rd(idx, d, r);
      chk(d, exp);
   endtask

   task automatic smp(input logic signed [15:0] x, input logic signed [15:0] y);
      @(posedge aclk);
      sample_valid <= 1'b1;
      sample <= {x, y, 16'sh0000};
      @(posedge aclk);
      sample_valid <= 1'b0;
      @(posedge aclk);
   endtask

   task automatic tally_and_finish;
      if (fail_count == 0 && check_count > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   // ---------------------------------------------------------------
   // Scenarios
   // ---------------------------------------------------------------
   task automatic t_reset;
      logic [7:0] idx[11] = '{8'h30, 8'h31, 8'h34, 8'h35, 8'h36, 8'h38, 8'h39, 8'h3c,
         8'h3d, 8'h3e, 8'h3f};
      foreach (idx[i])
         rc(idx[i], 32'h00000000);
      chk({29'h0, wake_irq, direction_irq, irq}, 32'h00000000);
      i_med_host_model.rd(8'h33, d, r);
      chk(32'(r), 32'(med_pkg::RESP_SLVERR));
      i_med_host_model.wr(8'h33, 8'h5a);
      chk(32'(bresp), 32'(med_pkg::RESP_SLVERR));
   endtask

   task automatic t_regs;
      logic [7:0] idx[7] = '{8'h34, 8'h35, 8'h36, 8'h3c, 8'h3d, 8'h3e, 8'h3f};
      foreach (idx[i])
      begin
         i_med_host_model.wr(idx[i], idx[i] ^ 8'ha5);
         rc(idx[i], {24'h000000, idx[i] ^ 8'ha5});
      end
   endtask

   task automatic t_wake_or;
      i_med_host_model.wr(8'h34, 8'h64);
      i_med_host_model.wr(8'h35, 8'h01);
      i_med_host_model.wr(8'h36, 8'h00);
      i_med_host_model.wr(8'h30, 8'h02);
      smp(16'sd300, 16'sd0);
      chk(32'(wake_irq), 32'h00000000);
      smp(16'sd357, 16'sd0);
      rc(8'h31, 32'h00000042);
      smp(16'sd356, 16'sd0);
      rc(8'h31, 32'h00000000);
      i_med_host_model.wr(8'h30, 8'h03);
      smp(-16'sd357, 16'sd0);
      rc(8'h31, 32'h00000041);
   endtask

   task automatic t_wake_and;
      i_med_host_model.wr(8'h30, 8'h8a);
      smp(16'sd400, 16'sd0);
      chk(32'(wake_irq), 32'h00000000);
      smp(16'sd400, 16'sd400);
      chk(32'(wake_irq), 32'h00000001);
   endtask

   task automatic t_duration;
      i_med_host_model.wr(8'h30, 8'h02);
      i_med_host_model.wr(8'h36, 8'h02);
      smp(16'sd0, 16'sd0);
      smp(16'sd400, 16'sd0);
      chk(32'(wake_irq), 32'h00000000);
      smp(16'sd400, 16'sd0);
      chk(32'(wake_irq), 32'h00000000);
      smp(16'sd400, 16'sd0);
      chk(32'(wake_irq), 32'h00000001);
      i_med_host_model.wr(8'h36, 8'h00);
   endtask

   task automatic t_latch;
      i_med_host_model.wr(8'h30, 8'h42);
      smp(16'sd400, 16'sd0);
      smp(16'sd0, 16'sd0);
      rc(8'h31, 32'h00000042);
      i_med_host_model.rd(8'h32, d, r);
      rc(8'h31, 32'h00000000);
   endtask

   task automatic t_irq;
      i_med_host_model.wr(8'h30, 8'h02);
      i_med_host_model.rd(8'h40, d, r);
      smp(16'sd400, 16'sd0);
      chk(32'(irq), 32'h00000000);
      i_med_host_model.wr(8'h41, 8'h01);
      chk(32'(irq), 32'h00000001);
      rc(8'h40, 32'h00000001);
      chk(32'(irq), 32'h00000000);
      i_med_host_model.wr(8'h30, 8'h00);
   endtask

   task automatic t_dir;
      i_med_host_model.wr(8'h3c, 8'h32);
      i_med_host_model.wr(8'h3d, 8'h00);
      i_med_host_model.wr(8'h3e, 8'hc8);
      i_med_host_model.wr(8'h3f, 8'h00);
      i_med_host_model.wr(8'h38, 8'h83);
      smp(16'sd250, 16'sd0);
      rc(8'h39, 32'h00000042);
      chk(32'(direction_irq), 32'h00000001);
      smp(16'sd250, 16'sd0);
      rc(8'h39, 32'h00000002);
      smp(16'sd10, 16'sd0);
      rc(8'h39, 32'h00000040);
      smp(-16'sd250, 16'sd0);
      rc(8'h39, 32'h00000041);
      i_med_host_model.wr(8'h38, 8'h03);
      smp(16'sd250, 16'sd0);
      chk(32'(direction_irq), 32'h00000000);
      i_med_host_model.wr(8'h38, 8'hc3);
      i_med_host_model.rd(8'h3a, d, r);
      smp(-16'sd250, 16'sd0);
      smp(-16'sd250, 16'sd0);
      rc(8'h39, 32'h00000041);
      i_med_host_model.rd(8'h3a, d, r);
      rc(8'h39, 32'h00000000);
   endtask

   // ---------------------------------------------------------------
   // Sequence and timeout
   // ---------------------------------------------------------------
   always @(posedge aclk)
   begin
      cyc <= cyc + 1;
      if (cyc == 20000)
      begin
         fail_count++;
         tally_and_finish;
      end
   end

   initial
   begin
      repeat (12) @(posedge aclk);
      aresetn <= 1'b1;
      t_reset;
      t_regs;
      t_wake_or;
      t_wake_and;
      t_duration;
      t_latch;
      t_irq;
      t_dir;
      tally_and_finish;
   end
endmodule // med_motion_event_detect_tb
